/* File: rtl/pcss_core.sv */
/*
  Program counter, upper holding latch, arithmetic status register and
  return stack of an 8-bit core, with a plain register port.
  Assumes the execution logic issues at most one flow operation and one
  arithmetic operation per clock, and that all inputs are synchronous.
*/
// Strobed register access is this design's own decision.
`include "pcss_cfg.svh"

module pcss_core
  import pcss_pkg::*;
#(
  parameter logic [`PCSS_PC_W-1:0] IRQ_VECTOR = `PCSS_IRQ_VECTOR,
  parameter int STACK_DEPTH = `PCSS_STACK_DEPTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata_r,
  input wire pcss_alu_req_t alu_req,
  input wire pcss_flow_req_t flow_req,
  input wire logic wdt_timeout,
  input wire logic sleep_enter,
  input wire logic watchdog_clear,
  input wire logic [6:0] dir_addr,
  output logic [7:0] alu_result_r,
  output logic [`PCSS_PC_W-1:0] pc_r,
  output logic [7:0] status_r,
  output logic [7:0] direct_addr_r
);

  // ========================================================================
  // Helper functions

  // Bank-insensitive file address match
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] base);
    addr_hit = ((addr & `PCSS_ADDR_LOW_MASK) == base);
  endfunction

  // Arithmetic result and flag effects
  function automatic pcss_alu_out_t alu_eval(input pcss_alu_req_t rq, input logic c_in);
    pcss_alu_out_t o;
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] bn;
    o = '0;
    sum = '0;
    nib = '0;
    bn = ~rq.b;
    case (rq.op)
      PCSS_ALU_ADD: begin
        sum = {1'b0, rq.a} + {1'b0, rq.b};
        nib = {1'b0, rq.a[3:0]} + {1'b0, rq.b[3:0]};
        o.res = sum[7:0];
        o.c = sum[8];
        o.dc = nib[4]; // Carry out of bit 3 [RULE22]
        o.upd_c = 1'b1;
        o.upd_dc = 1'b1;
        o.upd_z = 1'b1;
      end
      PCSS_ALU_SUB: begin
        // a minus b as a plus inverted b plus one [RULE2]
        sum = {1'b0, rq.a} + {1'b0, bn} + 9'h001;
        nib = {1'b0, rq.a[3:0]} + {1'b0, bn[3:0]} + 5'h01;
        o.res = sum[7:0];
        o.c = sum[8]; // One means no borrow [RULE2]
        o.dc = nib[4]; // One means no nibble borrow [RULE2]
        o.upd_c = 1'b1;
        o.upd_dc = 1'b1;
        o.upd_z = 1'b1;
      end
      PCSS_ALU_ROT_LEFT: begin
        o.res = {rq.a[6:0], c_in};
        o.c = rq.a[7]; // Top bit shifted out [RULE3]
        o.upd_c = 1'b1;
      end
      PCSS_ALU_ROT_RIGHT: begin
        o.res = {c_in, rq.a[7:1]};
        o.c = rq.a[0]; // Bottom bit shifted out [RULE3]
        o.upd_c = 1'b1;
      end
      PCSS_ALU_LOGIC: begin
        o.res = rq.b;
        o.upd_z = 1'b1;
      end
      PCSS_ALU_MOVE: begin
        o.res = rq.b;
      end
      default: begin
        o.res = '0;
      end
    endcase
    o.z = (o.res == 8'h00); // Zero result flag [RULE22]
    return o;
  endfunction

  // ========================================================================
  // Declarations

  logic [`PCSS_HOLD_W-1:0] hold_r;
  logic [`PCSS_HOLD_W-1:0] hold_nxt;
  logic [`PCSS_PC_W-1:0] pc_nxt;
  logic [7:0] status_nxt;
  logic [7:0] bus_rdata_nxt;
  logic [7:0] alu_result_nxt;
  logic [7:0] direct_addr_nxt;
  logic [`PCSS_PC_W-1:0] stack_top;
  logic push;
  logic pop;
  logic alu_go;
  logic bus_wr_status;
  logic bus_wr_low;
  logic bus_wr_hold;
  logic low_write;
  logic [7:0] low_data;
  pcss_alu_out_t alu_o;

  // ========================================================================
  // Request decode

  // Status decode covers 03h and 83h alike [RULE1]
  assign bus_wr_status = bus_wr && addr_hit(bus_addr, `PCSS_ADDR_STATUS);
  assign bus_wr_low = bus_wr && addr_hit(bus_addr, `PCSS_ADDR_PC_LOW);
  assign bus_wr_hold = bus_wr && addr_hit(bus_addr, `PCSS_ADDR_HOLD);
  assign alu_go = (alu_req.op != PCSS_ALU_NONE);
  assign alu_o = alu_eval(alu_req, status_r[`PCSS_ST_C]);

  // Any low-byte write, including an add to it, is a plain load [RULE9]
  assign low_write = bus_wr_low || (alu_go && alu_req.dest == PCSS_DST_PC_LOW);
  assign low_data = (alu_go && alu_req.dest == PCSS_DST_PC_LOW) ? alu_o.res : bus_wdata;

  // Stack actions from call, interrupt and the three returns
  assign push = (flow_req.op == PCSS_FLOW_CALL) || (flow_req.op == PCSS_FLOW_IRQ); // [RULE12]
  assign pop = (flow_req.op == PCSS_FLOW_RET) || (flow_req.op == PCSS_FLOW_RET_LIT) ||
               (flow_req.op == PCSS_FLOW_RET_INT); // [RULE13]

  // ========================================================================
  // Return stack

  pcss_stack #(
    .DEPTH(STACK_DEPTH),
    .WIDTH(`PCSS_PC_W)
  ) u_stack (
    .clk(clk),
    .reset_n(reset_n),
    .push(push),
    .pop(pop),
    .push_data(pc_r),
    .top_data(stack_top)
  );

  // ========================================================================
  // Program counter and holding latch

  // Next counter value; branches win over low-byte writes and steps
  always_comb begin
    pc_nxt = pc_r;
    hold_nxt = hold_r; // Stack actions never touch the latch [RULE14]
    if (bus_wr_hold) begin
      hold_nxt = bus_wdata[`PCSS_HOLD_W-1:0];
    end
    if (alu_go && alu_req.dest == PCSS_DST_HOLD) begin
      hold_nxt = alu_o.res[`PCSS_HOLD_W-1:0];
    end
    if (flow_req.op == PCSS_FLOW_STEP) begin
      pc_nxt = pc_r + `PCSS_PC_W'(1);
    end
    if (low_write) begin
      pc_nxt = {hold_r, low_data}; // Upper bits from latch 4:0 [RULE7] [RULE9]
    end
    case (flow_req.op)
      PCSS_FLOW_CALL, PCSS_FLOW_JUMP: begin
        pc_nxt = {hold_r[4:3], flow_req.target}; // [RULE8]
      end
      PCSS_FLOW_RET, PCSS_FLOW_RET_LIT, PCSS_FLOW_RET_INT: begin
        pc_nxt = stack_top; // [RULE13]
      end
      PCSS_FLOW_IRQ: begin
        pc_nxt = IRQ_VECTOR; // [RULE12]
      end
      default: begin
        pc_nxt = pc_nxt;
      end
    endcase
  end

  // Counter cleared by any reset [RULE4] [RULE6]
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pc_r <= `PCSS_PC_RESET; // [RULE6]
      hold_r <= `PCSS_HOLD_RESET;
    end else begin
      pc_r <= pc_nxt;
      hold_r <= hold_nxt;
    end
  end

  // ========================================================================
  // Status register

  // Writes, flag updates, then power and watchdog events
  always_comb begin
    status_nxt = status_r;
    if (bus_wr_status) begin
      // Expired and sleep flags keep their value [RULE18]
      status_nxt = (status_r & `PCSS_ST_PROT_MASK) | (bus_wdata & ~`PCSS_ST_PROT_MASK);
    end
    if (alu_go && alu_req.dest == PCSS_DST_STATUS) begin
      status_nxt = (status_r & `PCSS_ST_PROT_MASK) | (alu_o.res & ~`PCSS_ST_PROT_MASK); // [RULE18]
    end
    // Affected flags follow the result, overriding any written value [RULE17]
    if (alu_go && alu_o.upd_z) begin
      status_nxt[`PCSS_ST_Z] = alu_o.z; // [RULE22]
    end
    if (alu_go && alu_o.upd_dc) begin
      status_nxt[`PCSS_ST_DC] = alu_o.dc; // [RULE22]
    end
    if (alu_go && alu_o.upd_c) begin
      status_nxt[`PCSS_ST_C] = alu_o.c; // [RULE2] [RULE3]
    end
    if (watchdog_clear) begin
      status_nxt[`PCSS_ST_TO] = 1'b1;
      status_nxt[`PCSS_ST_PD] = 1'b1;
    end
    if (sleep_enter) begin
      status_nxt[`PCSS_ST_TO] = 1'b1;
      status_nxt[`PCSS_ST_PD] = 1'b0;
    end
    if (wdt_timeout) begin
      status_nxt[`PCSS_ST_TO] = 1'b0; // Time-out wins last [RULE19]
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      status_r <= `PCSS_ST_RESET;
    end else begin
      status_r <= status_nxt;
    end
  end

  // ========================================================================
  // Read port, result and direct address

  // Read data one cycle after the strobe; unmapped reads zero
  always_comb begin
    bus_rdata_nxt = 8'h00;
    if (bus_rd) begin
      if (addr_hit(bus_addr, `PCSS_ADDR_STATUS)) begin
        bus_rdata_nxt = status_r; // [RULE1]
      end else if (addr_hit(bus_addr, `PCSS_ADDR_PC_LOW)) begin
        bus_rdata_nxt = pc_r[7:0]; // Only the low byte is visible [RULE4] [RULE5]
      end else if (addr_hit(bus_addr, `PCSS_ADDR_HOLD)) begin
        bus_rdata_nxt = {3'h0, hold_r};
      end
    end
    alu_result_nxt = alu_go ? alu_o.res : alu_result_r;
    // Bank bit forms the top of a direct file address [RULE21]
    direct_addr_nxt = {status_r[`PCSS_ST_BANK_SEL], dir_addr};
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bus_rdata_r <= 8'h00;
      alu_result_r <= 8'h00;
      direct_addr_r <= 8'h00;
    end else begin
      bus_rdata_r <= bus_rdata_nxt;
      alu_result_r <= alu_result_nxt;
      direct_addr_r <= direct_addr_nxt;
    end
  end

endmodule

/* File: rtl/pcss_cfg.svh */
/*
  Constants of the program-flow and status core: file addresses, status
  field positions, reset values and widths, as `define macros.
  Assumes inclusion by bare name from the package and the design modules.
*/
// Function
// (RULE1) Status register answers at file address 03h and again at 83h.
// (RULE2) Subtract adds the two's complement; carry flags read as inverted borrow.
// (RULE3) Rotates load carry with the bit shifted out: top left, bottom right.
// (RULE4) Program counter is 13 bits; its low byte reads and writes.
// (RULE5) Upper counter bits are hidden; they come from the upper holding latch.
// (RULE6) Every reset clears the whole program counter.
// (RULE7) A low-byte write loads upper counter bits from holding latch bits 4:0.
// (RULE8) Call and jump take counter bits 12:11 from holding latch bits 4:3.
// (RULE9) Adding to the low byte is a plain low-byte write, no upper carry.
// (RULE10) Return stack holds eight 13-bit entries outside program and data space.
// (RULE11) Return stack pointer cannot be read or written by software.
// (RULE12) Call or interrupt branch pushes the program counter.
// (RULE13) Return, return-with-literal and interrupt return pop into the counter.
// (RULE14) Pushes and pops leave the upper holding latch untouched.
// (RULE15) Stack is circular; the ninth push overwrites the first.
// (RULE16) No flag reports stack overflow or underflow; wrapping is silent.
// (RULE17) Status as destination: zero, nibble and carry come from the result.
// (RULE18) Software cannot write the watchdog-expired or sleep-entered flags.
// (RULE19) Watchdog time-out clears the watchdog-expired flag.
// (RULE20) Software keeps indirect-bank and upper-bank bits at zero.
// (RULE21) Bank select bit picks bank 00h-7Fh or 80h-FFh for direct addressing.
// (RULE22) Zero flag marks a zero result; nibble flag marks carry out of bit 3.
`ifndef PCSS_CFG_SVH
`define PCSS_CFG_SVH

// ==========================================================================
// Widths
`define PCSS_PC_W 13
`define PCSS_HOLD_W 5
`define PCSS_STACK_DEPTH 8
`define PCSS_JUMP_W 11

// ==========================================================================
// File addresses (bank 0 and bank 1 mirror)
`define PCSS_ADDR_LOW_MASK 8'h7F
`define PCSS_ADDR_PC_LOW 8'h02
`define PCSS_ADDR_STATUS 8'h03
`define PCSS_ADDR_HOLD 8'h0A

// ==========================================================================
// Status field positions
`define PCSS_ST_IND_BANK 7
`define PCSS_ST_UP_BANK 6
`define PCSS_ST_BANK_SEL 5
`define PCSS_ST_TO 4
`define PCSS_ST_PD 3
`define PCSS_ST_Z 2
`define PCSS_ST_DC 1
`define PCSS_ST_C 0
`define PCSS_ST_PROT_MASK 8'h18

// ==========================================================================
// Reset values
`define PCSS_ST_RESET 8'h18
`define PCSS_PC_RESET 13'h0000
`define PCSS_HOLD_RESET 5'h00
`define PCSS_IRQ_VECTOR 13'h0004

`endif

/* File: rtl/pcss_pkg.sv */
/*
  Types of the program-flow and status core: operation codes and the
  request and result carriers.
  Assumes pcss_cfg.svh on the include path.
*/
package pcss_pkg;
`include "pcss_cfg.svh"

  // ========================================================================
  // Arithmetic operation and result destination
  typedef enum logic [2:0] {
    PCSS_ALU_NONE = 3'h0,
    PCSS_ALU_ADD = 3'h1,
    PCSS_ALU_SUB = 3'h2,
    PCSS_ALU_ROT_LEFT = 3'h3,
    PCSS_ALU_ROT_RIGHT = 3'h4,
    PCSS_ALU_LOGIC = 3'h5,
    PCSS_ALU_MOVE = 3'h6
  } pcss_alu_op_t;

  typedef enum logic [1:0] {
    PCSS_DST_NONE = 2'h0,
    PCSS_DST_STATUS = 2'h1,
    PCSS_DST_PC_LOW = 2'h2,
    PCSS_DST_HOLD = 2'h3
  } pcss_dest_t;

  // ========================================================================
  // Program flow operation
  typedef enum logic [2:0] {
    PCSS_FLOW_NONE = 3'h0,
    PCSS_FLOW_STEP = 3'h1,
    PCSS_FLOW_CALL = 3'h2,
    PCSS_FLOW_JUMP = 3'h3,
    PCSS_FLOW_RET = 3'h4,
    PCSS_FLOW_RET_LIT = 3'h5,
    PCSS_FLOW_RET_INT = 3'h6,
    PCSS_FLOW_IRQ = 3'h7
  } pcss_flow_op_t;

  typedef struct packed {
    pcss_alu_op_t op;
    pcss_dest_t dest;
    logic [7:0] a;
    logic [7:0] b;
  } pcss_alu_req_t;

  typedef struct packed {
    pcss_flow_op_t op;
    logic [`PCSS_JUMP_W-1:0] target;
  } pcss_flow_req_t;

  typedef struct packed {
    logic [7:0] res;
    logic c;
    logic dc;
    logic z;
    logic upd_c;
    logic upd_dc;
    logic upd_z;
  } pcss_alu_out_t;

endpackage

/* File: rtl/pcss_stack.sv */
/*
  Circular return stack of program counter values.
  Assumes push and pop are never requested in the same cycle.
*/
`include "pcss_cfg.svh"

module pcss_stack
  import pcss_pkg::*;
#(
  parameter int DEPTH = `PCSS_STACK_DEPTH,
  parameter int WIDTH = `PCSS_PC_W
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic push,
  input wire logic pop,
  input wire logic [WIDTH-1:0] push_data,
  output logic [WIDTH-1:0] top_data
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [PW-1:0] ptr_r;
  logic [PW-1:0] ptr_nxt;
  logic [PW-1:0] top_idx;

  // Entry below the pointer is the newest
  assign top_idx = ptr_r - PW'(1);
  assign top_data = mem_r[top_idx];

  // Pointer wraps modulo depth, no overflow report [RULE15] [RULE16]
  always_comb begin
    ptr_nxt = ptr_r;
    for (int i = 0; i < DEPTH; i++) begin
      mem_nxt[i] = mem_r[i];
    end
    if (push) begin
      mem_nxt[ptr_r] = push_data; // Oldest slot reused after wrap [RULE15]
      ptr_nxt = ptr_r + PW'(1);
    end else if (pop) begin
      ptr_nxt = top_idx; // Underflow wraps silently [RULE16]
    end
  end

  // Storage and hidden pointer, never on the bus [RULE10] [RULE11]
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ptr_r <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      ptr_r <= ptr_nxt;
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= mem_nxt[i];
      end
    end
  end

endmodule

/* File: bench/pcss_core_sva.sv */
/* Port checks of the program-flow and status core.
   Assumes binding into pcss_core and pcss_pkg compiled first. */
module pcss_core_sva
  import pcss_pkg::*;
#(
  parameter logic [12:0] IRQ_VECTOR = 13'h0004
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata_r,
  input wire pcss_alu_req_t alu_req,
  input wire pcss_flow_req_t flow_req,
  input wire logic wdt_timeout,
  input wire logic sleep_enter,
  input wire logic watchdog_clear,
  input wire logic [7:0] alu_result_r,
  input wire logic [12:0] pc_r,
  input wire logic [7:0] status_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // ==========================================================================
  // Flow sequences and reset property
  sequence s_call;
    flow_req.op == PCSS_FLOW_CALL;
  endsequence
  sequence s_ret;
    flow_req.op == PCSS_FLOW_RET;
  endsequence
  property p_pc_cleared;
    disable iff (1'b0) !reset_n |=> pc_r == 13'h0000;
  endproperty

  // ==========================================================================
  // Assertions
  chk_pc_cleared: assert property (p_pc_cleared)
    else $error("pc not cleared by reset");
  chk_status_mirror: assert property (bus_rd && bus_addr[6:0] == 7'h03
    |=> bus_rdata_r == $past(status_r)) else $error("status read mismatch");
  chk_pcl_load: assert property (bus_wr && bus_addr[6:0] == 7'h02 &&
    flow_req.op inside {PCSS_FLOW_NONE, PCSS_FLOW_STEP} && alu_req.op == PCSS_ALU_NONE
    |=> pc_r[7:0] == $past(bus_wdata)) else $error("pc low byte not loaded");
  chk_jump_target: assert property (flow_req.op inside {PCSS_FLOW_CALL, PCSS_FLOW_JUMP}
    |=> pc_r[10:0] == $past(flow_req.target)) else $error("branch target wrong");
  chk_step_count: assert property (flow_req.op == PCSS_FLOW_STEP && !bus_wr &&
    alu_req.op == PCSS_ALU_NONE |=> pc_r == $past(pc_r) + 13'h0001) else $error("step wrong");
  chk_irq_vector: assert property (flow_req.op == PCSS_FLOW_IRQ
    |=> pc_r == IRQ_VECTOR) else $error("interrupt vector wrong");
  chk_call_return: assert property (s_call ##1 s_ret
    |=> pc_r == $past(pc_r, 2)) else $error("return address wrong");
  chk_add_carry: assert property (alu_req.op == PCSS_ALU_ADD
    |=> {status_r[0], alu_result_r} == $past({1'b0, alu_req.a} + {1'b0, alu_req.b}))
    else $error("add result or carry wrong");
  chk_sub_borrow: assert property (alu_req.op == PCSS_ALU_SUB
    |=> {status_r[0], alu_result_r} == $past({1'b0, alu_req.a} + {1'b0, ~alu_req.b} + 9'h001))
    else $error("subtract result or borrow wrong");
  chk_rotate_carry: assert property (alu_req.op inside {PCSS_ALU_ROT_LEFT, PCSS_ALU_ROT_RIGHT}
    |=> status_r[0] == $past(alu_req.op == PCSS_ALU_ROT_LEFT ? alu_req.a[7] : alu_req.a[0]))
    else $error("rotate carry wrong");
  chk_prot_flags: assert property (bus_wr && bus_addr[6:0] == 7'h03 && !wdt_timeout &&
    !sleep_enter && !watchdog_clear |=> $stable(status_r[4:3])) else $error("flags written");
  chk_wdt_clear: assert property (wdt_timeout |=> !status_r[4])
    else $error("watchdog flag not cleared");
endmodule

bind pcss_core pcss_core_sva #(.IRQ_VECTOR(IRQ_VECTOR)) u_sva (
  .clk(clk), .reset_n(reset_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata_r(bus_rdata_r), .alu_req(alu_req),
  .flow_req(flow_req), .wdt_timeout(wdt_timeout), .sleep_enter(sleep_enter),
  .watchdog_clear(watchdog_clear), .alu_result_r(alu_result_r), .pc_r(pc_r),
  .status_r(status_r)
);

/* File: bench/pcss_exec_model.sv */
/* Model of the instruction execution logic that issues flow and ALU work.
   Assumes each task is called just after a rising clock edge. */
module pcss_exec_model
  import pcss_pkg::*;
(
  input wire logic clk,
  output pcss_alu_req_t alu_req,
  output pcss_flow_req_t flow_req
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle at time zero
  initial begin
    alu_req = '0;
    flow_req = '0;
  end

  // One flow request for one cycle
  task automatic flow(input pcss_flow_op_t op, input logic [10:0] tgt);
    @(posedge clk);
    flow_req <= '{op: op, target: tgt};
    @(posedge clk);
    flow_req <= '0;
    #1;
  endtask

  // Call with a return right behind it
  task automatic call_ret(input logic [10:0] tgt);
    @(posedge clk);
    flow_req <= '{op: PCSS_FLOW_CALL, target: tgt};
    @(posedge clk);
    flow_req <= '{op: PCSS_FLOW_RET, target: 11'h000};
    @(posedge clk);
    flow_req <= '0;
    #1;
  endtask

  // One ALU request for one cycle
  task automatic alu(input pcss_alu_op_t op, input pcss_dest_t dst, input logic [7:0] a, b);
    @(posedge clk);
    alu_req <= '{op: op, dest: dst, a: a, b: b};
    @(posedge clk);
    alu_req <= '0;
    #1;
  endtask
endmodule

/* File: bench/pcss_core_tb_top.sv */
/* Self-checking bench of the program-flow and status core.
   Assumes pcss_pkg, the design, the checker and the execution model. */
module pcss_core_tb_top
  import pcss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] bus_addr = 8'h00;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [2:0] ev = 3'h0;
  logic [7:0] bus_rdata_r, alu_result_r, status_r, direct_addr_r, d;
  logic [12:0] pc_r;
  pcss_alu_req_t alu_req;
  pcss_flow_req_t flow_req;
  int num_errors = 0;
  int tests_run = 0;

  // 200 MHz clock
  always #2.5 clk = ~clk;

  pcss_exec_model m (.clk(clk), .alu_req(alu_req), .flow_req(flow_req));
  pcss_core dut (
    .clk(clk), .reset_n(reset_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata_r(bus_rdata_r), .alu_req(alu_req),
    .flow_req(flow_req), .wdt_timeout(ev[2]), .sleep_enter(ev[1]),
    .watchdog_clear(ev[0]), .dir_addr(7'h05), .alu_result_r(alu_result_r),
    .pc_r(pc_r), .status_r(status_r), .direct_addr_r(direct_addr_r)
  );

  // ==========================================================================
  // Bus, event and compare tasks
  task automatic wr(input logic [7:0] a, dat);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= dat;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 d = bus_rdata_r;
  endtask
  task automatic pulse(input logic [2:0] e);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= 3'h0;
    #1;
  endtask
  task automatic chk8(input string n, input logic [7:0] e, g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk13(input string n, input logic [12:0] e, g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    @(posedge clk);
    reset_n <= 1'b0;
    @(posedge clk);
    reset_n <= 1'b1;
    #1 chk13("pc", 13'h0000, pc_r);
    chk8("status", 8'h18, status_r);
    rd(8'h03);
    chk8("status low", 8'h18, d);
    rd(8'h83);
    chk8("status high", 8'h18, d);
    rd(8'h0A);
    chk8("holding", 8'h00, d);
  endtask
  task automatic t_pcl();
    wr(8'h0A, 8'h1F);
    wr(8'h02, 8'hAB);
    chk13("pc", 13'h1FAB, pc_r);
    rd(8'h82);
    chk8("pc low", 8'hAB, d);
    rd(8'h8A);
    chk8("holding", 8'h1F, d);
    wr(8'h05, 8'h55);
    rd(8'h05);
    chk8("unmapped", 8'h00, d);
  endtask
  task automatic t_flow();
    m.flow(PCSS_FLOW_JUMP, 11'h123);
    chk13("jump", 13'h1923, pc_r);
    m.flow(PCSS_FLOW_STEP, 11'h000);
    chk13("step", 13'h1924, pc_r);
    m.call_ret(11'h055);
    chk13("return", 13'h1924, pc_r);
    rd(8'h0A);
    chk8("holding", 8'h1F, d);
    m.flow(PCSS_FLOW_IRQ, 11'h000);
    chk13("vector", 13'h0004, pc_r);
    m.flow(PCSS_FLOW_RET_INT, 11'h000);
    chk13("interrupt return", 13'h1924, pc_r);
  endtask
  task automatic t_wrap();
    pcss_flow_op_t ops[3] = '{PCSS_FLOW_RET, PCSS_FLOW_RET_LIT, PCSS_FLOW_RET_INT};
    wr(8'h0A, 8'h00);
    m.flow(PCSS_FLOW_JUMP, 11'h000);
    for (int i = 1; i <= 9; i++) begin
      m.flow(PCSS_FLOW_CALL, 11'(i));
    end
    for (int i = 0; i < 9; i++) begin
      m.flow(ops[i % 3], 11'h000);
      chk13("pop", (i < 8) ? 13'(8 - i) : 13'h0008, pc_r);
    end
    chk8("status", 8'h18, status_r);
  endtask
  task automatic t_table();
    wr(8'h0A, 8'h01);
    wr(8'h02, 8'hF0);
    m.alu(PCSS_ALU_ADD, PCSS_DST_PC_LOW, 8'hF0, 8'h20);
    chk13("pc add", 13'h0110, pc_r);
  endtask
  task automatic t_alu();
    pcss_alu_op_t op[6] = '{PCSS_ALU_ADD, PCSS_ALU_ADD, PCSS_ALU_SUB, PCSS_ALU_SUB,
      PCSS_ALU_ROT_LEFT, PCSS_ALU_ROT_RIGHT};
    logic [7:0] a[6] = '{8'h0F, 8'hFF, 8'h05, 8'h03, 8'h81, 8'h02};
    logic [7:0] b[6] = '{8'h01, 8'h01, 8'h05, 8'h05, 8'h00, 8'h00};
    logic [7:0] r[6] = '{8'h10, 8'h00, 8'h00, 8'hFE, 8'h02, 8'h81};
    logic [7:0] f[6] = '{8'h02, 8'h07, 8'h07, 8'h00, 8'h01, 8'h00};
    for (int i = 0; i < 6; i++) begin
      m.alu(op[i], PCSS_DST_NONE, a[i], b[i]);
      chk8("result", r[i], alu_result_r);
      chk8("flags", f[i], {5'h00, status_r[2:0]});
    end
  endtask
  task automatic t_status();
    wr(8'h03, 8'h00);
    chk8("status", 8'h18, status_r);
    wr(8'h03, 8'h20);
    @(posedge clk);
    #1 chk8("direct", 8'h85, direct_addr_r);
    m.alu(PCSS_ALU_LOGIC, PCSS_DST_STATUS, 8'h00, 8'h04);
    chk8("status dest", 8'h18, status_r);
    pulse(3'h4);
    chk8("timeout", 8'h08, status_r);
    pulse(3'h2);
    chk8("sleep", 8'h10, status_r);
    pulse(3'h1);
    chk8("clear", 8'h18, status_r);
  endtask

  // Run limit
  initial begin
    #100000;
    num_errors++;
    $display("Error run limit expected done seen hang");
    finish_test();
  end

  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_pcl();
    t_flow();
    t_reset();
    t_wrap();
    t_table();
    t_alu();
    t_status();
    finish_test();
  end
endmodule
